//--- flash_self_program_ctrl.sv
// Self-programming sequencer for on-chip program flash.
// Assumes a CPU core on the same clock issuing control writes and the
// store-program strobe, and a flash macro taking page program requests.
//
// Operation
// - Boot fuse picks application or loader reset
// - No CPU path changes fuse values
// - Pointer built from low, high, extension bytes
// - Low bits select word, high bits page
// - Target address latched at operation start
// - Pointer bit 0 selects byte
// - Erase pattern plus store within four cycles
// - Halt CPU only for halting section target
// - Load pattern stores data word at word
// - Buffer cleared after write, reenable, reset
// - Each buffer word writable once per clear
// - EEPROM write during loading discards buffer
// - Write pattern programs buffer into page
// - Loads any order, before or after erase
// - Interrupt held while enable bit clear
// - Section busy blocks reads, sets busy bit
// - Busy stays until reenable command
// - Lock pattern programs zero data bits
// - Lock programming keeps flash readable, no halt
// - Armed bits clear without store in four
// - Erase, write, lock each last 3.7 to 4.5 ms
// - EEPROM write blocks flash commands
`timescale 1ns/100ps
`include "flash_self_program_regs.svh"
module flash_self_program_ctrl #(
	parameter int PAGE_WORDS_LOG2 = 7,
	parameter int ADDR_BITS = 17,
	parameter logic [23:0] LOADER_RESET_ADDR = 24'h01F000,
	parameter logic [23:0] HALT_SECTION_START = 24'h01E000,
	parameter int PROG_CYCLES =
		(`PROG_TIME_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic boot_reset_fuse,
	input wire logic ctl_wr,
	input wire logic [7:0] ctl_wdata,
	input wire logic store_strobe,
	input wire logic [7:0] flash_addr_pointer_low,
	input wire logic [7:0] flash_addr_pointer_high,
	input wire logic [7:0] flash_addr_extension,
	input wire logic [7:0] data_word_low,
	input wire logic [7:0] data_word_high,
	input wire logic eeprom_busy,
	output logic [7:0] self_program_control,
	output logic [23:0] reset_vector,
	output logic cpu_halt,
	output logic concurrent_read_block,
	output logic spm_irq,
	output logic flash_erase,
	output logic flash_write,
	output logic [ADDR_BITS-PAGE_WORDS_LOG2-1:0] page_index_field,
	output logic [15:0] prog_data,
	output logic [PAGE_WORDS_LOG2-1:0] prog_word,
	output logic [5:0] lock_bits,
	output logic byte_select_bit
);
	import flash_self_program_pkg::*;

	localparam int PW = PAGE_WORDS_LOG2;
	localparam int PG = ADDR_BITS - PAGE_WORDS_LOG2;

	seq_state_t state_reg;
	op_t op_reg;
	logic [2:0] arm_cnt_reg;
	logic [31:0] timer_reg;
	logic [23:0] pointer;
	logic [PG-1:0] page_reg;
	logic [PW-1:0] wr_word_reg;
	logic [PW-1:0] scan_reg;
	logic [PW-1:0] rd_word_reg;
	logic fuse_meta_reg;
	logic fuse_sync_reg;
	logic busy_reg;
	logic irq_en_reg;
	logic loading_reg;
	logic halt_target;
	logic buf_clear;
	logic buf_wr;
	logic [15:0] buf_rd;
	logic store_go;
	op_t cmd_op;

	// ----------------------------------------
	// Address formation
	// ----------------------------------------
	assign pointer = {flash_addr_extension, flash_addr_pointer_high,
		flash_addr_pointer_low};
	// Word address drops the byte select bit
	assign halt_target = ({1'b0, pointer[23:1]} >= HALT_SECTION_START);

	always_comb begin
		case (ctl_wdata[6:0])
			`CMD_LOAD: cmd_op = OP_LOAD;
			`CMD_ERASE: cmd_op = OP_ERASE;
			`CMD_WRITE: cmd_op = OP_WRITE;
			`CMD_LOCK: cmd_op = OP_LOCK;
			`CMD_REENABLE: cmd_op = OP_REENABLE;
			default: cmd_op = OP_NONE;
		endcase
	end

	assign store_go = (state_reg == ST_ARMED) && store_strobe;

	// ----------------------------------------
	// Reset vector; fuse has no write path here
	// ----------------------------------------
	// Fuse level is unclocked, so it is synchronised first
	always_ff @(posedge mclk) begin
		fuse_meta_reg <= boot_reset_fuse;
		fuse_sync_reg <= fuse_meta_reg;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			reset_vector <= `APP_RESET_ADDR;
		end else begin
			reset_vector <= fuse_sync_reg ? `APP_RESET_ADDR :
				LOADER_RESET_ADDR;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_NONE;
			arm_cnt_reg <= 3'd0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					// EEPROM activity blocks arming entirely
					if (ctl_wr && ctl_wdata[`SPC_ENABLE_BIT] &&
						cmd_op != OP_NONE && !eeprom_busy) begin
						state_reg <= ST_ARMED;
						op_reg <= cmd_op;
						arm_cnt_reg <= 3'd0;
					end
				end
				ST_ARMED: begin
					if (store_strobe) begin
						case (op_reg)
							OP_ERASE, OP_WRITE: state_reg <= ST_PROG;
							OP_LOCK: state_reg <= ST_LOCK;
							default: state_reg <= ST_DONE;
						endcase
					end else if (arm_cnt_reg == `ARM_WINDOW_CYCLES - 3'd1) begin
						state_reg <= ST_IDLE;
						op_reg <= OP_NONE;
					end else begin
						arm_cnt_reg <= arm_cnt_reg + 3'd1;
					end
				end
				ST_PROG, ST_LOCK: begin
					if (timer_reg == 32'd0) begin
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_reg <= ST_IDLE;
					op_reg <= OP_NONE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Latched target and program timer
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			page_reg <= '0;
			wr_word_reg <= '0;
			byte_select_bit <= 1'b0;
		end else if (store_go) begin
			page_reg <= pointer[ADDR_BITS:PW+1];
			wr_word_reg <= pointer[PW:1];
			byte_select_bit <= pointer[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			timer_reg <= 32'd0;
		end else if (store_go) begin
			timer_reg <= 32'(PROG_CYCLES - 1);
		end else if (timer_reg != 32'd0) begin
			timer_reg <= timer_reg - 32'd1;
		end
	end

	// ----------------------------------------
	// Page buffer control
	// ----------------------------------------
	assign buf_wr = store_go && op_reg == OP_LOAD;
	assign buf_clear = (state_reg == ST_DONE && op_reg == OP_WRITE) ||
		(store_go && op_reg == OP_REENABLE) ||
		(loading_reg && eeprom_busy);

	always_ff @(posedge mclk) begin
		if (srst) begin
			loading_reg <= 1'b0;
		end else if (buf_wr) begin
			loading_reg <= 1'b1;
		end else if (buf_clear) begin
			loading_reg <= 1'b0;
		end
	end

	page_buffer #(
		.WORDS_LOG2(PW)
	) u_buffer (
		.mclk(mclk),
		.srst(srst),
		.clear(buf_clear),
		.wr_en(buf_wr),
		.wr_word(pointer[PW:1]),
		.wr_data({data_word_high, data_word_low}),
		.rd_word(scan_reg),
		.rd_data(buf_rd)
	);

	// Buffer streamed to the flash macro one word per cycle
	always_ff @(posedge mclk) begin
		if (srst || store_go) begin
			scan_reg <= '0;
		end else if (state_reg == ST_PROG && op_reg == OP_WRITE) begin
			scan_reg <= scan_reg + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			prog_data <= 16'hFFFF;
			prog_word <= '0;
			rd_word_reg <= '0;
		end else begin
			// Index tracks the buffer's registered read
			rd_word_reg <= scan_reg;
			prog_data <= buf_rd;
			prog_word <= rd_word_reg;
		end
	end

	// ----------------------------------------
	// Flash strobes and section status
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			flash_erase <= 1'b0;
			flash_write <= 1'b0;
			page_index_field <= '0;
			lock_bits <= `LOCK_RESET;
		end else begin
			flash_erase <= state_reg == ST_PROG && op_reg == OP_ERASE;
			flash_write <= state_reg == ST_PROG && op_reg == OP_WRITE;
			page_index_field <= page_reg;
			if (store_go && op_reg == OP_LOCK) begin
				lock_bits <= lock_bits & data_word_low[5:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			busy_reg <= 1'b0;
		end else if (store_go && (op_reg == OP_ERASE ||
			op_reg == OP_WRITE)) begin
			busy_reg <= 1'b1;
		end else if (store_go && op_reg == OP_REENABLE &&
			state_reg != ST_PROG) begin
			busy_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cpu_halt <= 1'b0;
			concurrent_read_block <= 1'b0;
		end else begin
			// Lock programming never halts nor blocks
			cpu_halt <= (store_go && halt_target &&
				(op_reg == OP_ERASE || op_reg == OP_WRITE)) ||
				(cpu_halt && state_reg == ST_PROG);
			concurrent_read_block <= busy_reg || (store_go &&
				(op_reg == OP_ERASE || op_reg == OP_WRITE));
		end
	end

	// ----------------------------------------
	// Control register view and interrupt
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_en_reg <= 1'b0;
		end else if (ctl_wr) begin
			irq_en_reg <= ctl_wdata[`SPC_IRQ_EN_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			self_program_control <= `SPC_RESET;
			spm_irq <= 1'b0;
		end else begin
			self_program_control <= `SPC_RESET;
			self_program_control[`SPC_IRQ_EN_BIT] <= irq_en_reg;
			self_program_control[`SPC_BUSY_BIT] <= busy_reg;
			if (state_reg != ST_IDLE && state_reg != ST_DONE) begin
				self_program_control[`SPC_ENABLE_BIT] <= 1'b1;
				self_program_control[`SPC_ERASE_BIT] <= op_reg == OP_ERASE;
				self_program_control[`SPC_WRITE_BIT] <= op_reg == OP_WRITE;
				self_program_control[`SPC_LOCK_BIT] <= op_reg == OP_LOCK;
				self_program_control[`SPC_REENABLE_BIT] <=
					op_reg == OP_REENABLE;
			end
			spm_irq <= irq_en_reg &&
				(state_reg == ST_IDLE || state_reg == ST_DONE);
		end
	end
endmodule : flash_self_program_ctrl

//--- flash_self_program_regs.svh
// Constants for the flash self-programming controller.
// Assumes an 8 ns core clock and a 16-bit wide flash word.
`ifndef FLASH_SELF_PROGRAM_REGS_SVH
`define FLASH_SELF_PROGRAM_REGS_SVH

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SPC_ENABLE_BIT 0
`define SPC_ERASE_BIT 1
`define SPC_WRITE_BIT 2
`define SPC_LOCK_BIT 3
`define SPC_REENABLE_BIT 4
`define SPC_BUSY_BIT 6
`define SPC_IRQ_EN_BIT 7
`define SPC_RESET 8'h00

// ----------------------------------------
// Command patterns, bit 7 ignored
// ----------------------------------------
`define CMD_LOAD 7'h01
`define CMD_ERASE 7'h03
`define CMD_WRITE 7'h05
`define CMD_LOCK 7'h09
`define CMD_REENABLE 7'h11

// ----------------------------------------
// Timing
// ----------------------------------------
`define ARM_WINDOW_CYCLES 3'd4
`define CLK_PERIOD_NS 8
`define PROG_TIME_MIN_NS 3700000
`define PROG_TIME_MAX_NS 4500000
`define APP_RESET_ADDR 24'h000000
`define LOCK_RESET 6'h3F

`endif

//--- flash_self_program_pkg.sv
// Types shared by the flash self-programming controller.
// Assumes the constants header is included where numbers are needed.
package flash_self_program_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARMED = 5'h02,
		ST_PROG = 5'h04,
		ST_LOCK = 5'h08,
		ST_DONE = 5'h10
	} seq_state_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_LOAD = 3'h1,
		OP_ERASE = 3'h2,
		OP_WRITE = 3'h3,
		OP_LOCK = 3'h4,
		OP_REENABLE = 3'h5
	} op_t;
endpackage : flash_self_program_pkg

//--- page_buffer.sv
// Temporary page buffer with write-once tracking per word.
// Assumes the sequencer clears it and writes one word per cycle.
`timescale 1ns/100ps
module page_buffer #(
	parameter int WORDS_LOG2 = 7
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic clear,
	input wire logic wr_en,
	input wire logic [WORDS_LOG2-1:0] wr_word,
	input wire logic [15:0] wr_data,
	input wire logic [WORDS_LOG2-1:0] rd_word,
	output logic [15:0] rd_data
);
	logic [15:0] mem [0:(1<<WORDS_LOG2)-1];
	logic [(1<<WORDS_LOG2)-1:0] used_reg;

	// ----------------------------------------
	// Write-once flags
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			used_reg <= '0;
		end else begin
			if (clear) begin
				used_reg <= '0;
			end
			// A load in the clearing cycle survives
			if (wr_en) begin
				used_reg[wr_word] <= 1'b1;
			end
		end
	end

	// Erased words read as all ones, like erased flash
	always_ff @(posedge mclk) begin
		if (wr_en && (clear || !used_reg[wr_word])) begin
			mem[wr_word] <= wr_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rd_data <= 16'hFFFF;
		end else if (used_reg[rd_word]) begin
			rd_data <= mem[rd_word];
		end else begin
			rd_data <= 16'hFFFF;
		end
	end
endmodule : page_buffer

//--- flash_self_program_ctrl_sva.sv
// Port checker for the flash self-programming sequencer.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module flash_self_program_ctrl_sva #(
	parameter int PAGE_WORDS_LOG2 = 7,
	parameter int ADDR_BITS = 17,
	parameter logic [23:0] HALT_SECTION_START = 24'h01E000,
	parameter int PROG_CYCLES = 20
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic ctl_wr,
	input wire logic [7:0] ctl_wdata,
	input wire logic store_strobe,
	input wire logic eeprom_busy,
	input wire logic [7:0] self_program_control,
	input wire logic cpu_halt,
	input wire logic concurrent_read_block,
	input wire logic spm_irq,
	input wire logic flash_erase,
	input wire logic flash_write,
	input wire logic [ADDR_BITS-PAGE_WORDS_LOG2-1:0] page_index_field
);
	logic [7:0] spc;
	logic run;
	int run_reg;
	assign spc = self_program_control;
	assign run = flash_erase | flash_write;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// Counter, since a repetition this long would stall the tools
	always_ff @(posedge mclk) begin
		run_reg <= run ? run_reg + 1 : 0;
	end
	a_arm_taken: assert property (ctl_wr && ctl_wdata[0] && !eeprom_busy
		&& !spc[0] && !$past(spc[0]) && ctl_wdata[6:0] inside {7'h01,
		7'h03, 7'h05, 7'h09, 7'h11} |-> ##2 spc[0])
		else $error("arm lost");
	a_arm_expiry: assert property ($rose(spc[0]) ##0 !store_strobe [*4]
		|-> ##[1:2] !spc[0]) else $error("armed too long");
	a_op_start: assert property (store_strobe && spc[0] && !run
		|-> ##2 flash_erase == $past(spc[1], 2)
		&& flash_write == $past(spc[2], 2)) else $error("bad start");
	a_page_held: assert property (run && $past(run)
		|-> $stable(page_index_field)) else $error("page moved");
	a_halt_target: assert property (run && $past(run) |-> cpu_halt ==
		(24'(page_index_field) << PAGE_WORDS_LOG2) >= HALT_SECTION_START)
		else $error("halt wrong");
	a_lock_runs: assert property (store_strobe && spc[0] && spc[3]
		|=> (!cpu_halt && !run) [*8]) else $error("lock halted");
	a_busy_block: assert property (run || spc[6] |-> spc[6]
		&& concurrent_read_block) else $error("section open");
	a_busy_held: assert property (spc[6] && !spc[4] && !ctl_wr
		&& !store_strobe |=> spc[6]) else $error("busy dropped");
	a_irq_level: assert property (spc[7] && !spc[0]
		&& $past(spc[7] && !spc[0]) |-> spm_irq) else $error("irq missing");
	a_prog_time: assert property ($fell(run)
		|-> run_reg == PROG_CYCLES) else $error("program time");
	a_done_clear: assert property ($fell(run)
		|-> ##[0:3] !spc[0]) else $error("enable stuck");
	c_erase: cover property ($rose(flash_erase));
	c_write: cover property ($rose(flash_write));
	c_lock: cover property (store_strobe && spc[0] && spc[3]);
endmodule : flash_self_program_ctrl_sva
bind flash_self_program_ctrl flash_self_program_ctrl_sva #(
	.PAGE_WORDS_LOG2(PAGE_WORDS_LOG2), .ADDR_BITS(ADDR_BITS),
	.HALT_SECTION_START(HALT_SECTION_START), .PROG_CYCLES(PROG_CYCLES)
) chk (.mclk(mclk), .srst(srst), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
	.store_strobe(store_strobe), .eeprom_busy(eeprom_busy),
	.self_program_control(self_program_control), .cpu_halt(cpu_halt),
	.concurrent_read_block(concurrent_read_block), .spm_irq(spm_irq),
	.flash_erase(flash_erase), .flash_write(flash_write),
	.page_index_field(page_index_field));

//--- cpu_model.sv
// CPU core model issuing control writes and store strobes.
// Assumes the sequencer samples its inputs on the rising edge.
`timescale 1ns/100ps
module cpu_model (
	input wire logic mclk,
	input wire logic [7:0] self_program_control,
	output logic ctl_wr,
	output logic [7:0] ctl_wdata,
	output logic store_strobe
);
	initial begin
		ctl_wr = 1'b0;
		ctl_wdata = 8'h00;
		store_strobe = 1'b0;
	end
	// No interrupt splits arm and store; gap above 4 is a late store
	task automatic spm(input logic [7:0] cmd, input int gap);
		int i;
		@(negedge mclk);
		ctl_wr = 1'b1;
		ctl_wdata = cmd;
		@(negedge mclk);
		ctl_wr = 1'b0;
		ctl_wdata = ~cmd;
		repeat (gap - 1) @(negedge mclk);
		store_strobe = 1'b1;
		@(negedge mclk);
		store_strobe = 1'b0;
		for (i = 0; i < 100 && self_program_control[0] !== 1'b0; i++)
			@(negedge mclk);
	endtask : spm
endmodule : cpu_model

//--- flash_self_program_ctrl_tb.sv
// Testbench for the flash self-programming sequencer.
// Assumes cpu_model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module flash_self_program_ctrl_tb;
	import flash_self_program_pkg::*;
	localparam int PW = 7;
	localparam int PG = 10;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic fuse = 1'b1;
	logic eeprom_busy = 1'b0;
	logic [23:0] ptr = 24'h000000;
	logic [15:0] dw = 16'h0000;
	logic ctl_wr, store_strobe, cpu_halt, crb, spm_irq, fe, fw, bsel;
	logic [7:0] ctl_wdata, spc;
	logic [23:0] rvec;
	logic [PG-1:0] page;
	logic [15:0] pdata;
	logic [PW-1:0] pword;
	logic [5:0] lock;
	logic [5:0] lock_m = 6'h3F;
	logic halt_seen = 1'b0;
	logic [1:0] run_seen = 2'b00;
	logic [15:0] exp_w;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int buf_m [int];
	always #4 mclk = ~mclk;
	flash_self_program_ctrl #(.PROG_CYCLES(20)) dut (.mclk(mclk),
		.srst(srst), .boot_reset_fuse(fuse), .ctl_wr(ctl_wr),
		.ctl_wdata(ctl_wdata), .store_strobe(store_strobe),
		.flash_addr_pointer_low(ptr[7:0]), .flash_addr_pointer_high(ptr[15:8]),
		.flash_addr_extension(ptr[23:16]), .data_word_low(dw[7:0]),
		.data_word_high(dw[15:8]), .eeprom_busy(eeprom_busy),
		.self_program_control(spc), .reset_vector(rvec), .cpu_halt(cpu_halt),
		.concurrent_read_block(crb), .spm_irq(spm_irq), .flash_erase(fe),
		.flash_write(fw), .page_index_field(page), .prog_data(pdata),
		.prog_word(pword), .lock_bits(lock), .byte_select_bit(bsel));
	cpu_model cpu (.mclk(mclk), .self_program_control(spc), .ctl_wr(ctl_wr),
		.ctl_wdata(ctl_wdata), .store_strobe(store_strobe));
	// Ceiling: nine 20-cycle operations, with wide margin
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 5000) begin
			num_errors++;
			summarize();
		end
	end
	always @(negedge mclk) begin
		if (fw === 1'b1) begin
			exp_w = 16'hFFFF;
			if (buf_m.exists(int'(pword)))
				exp_w = 16'(buf_m[int'(pword)]);
			`CHK(pdata, exp_w)
		end
		if ((fe | fw) === 1'b1 && cpu_halt === 1'b1)
			halt_seen = 1'b1;
		if (fe === 1'b1)
			run_seen[0] = 1'b1;
		if (fw === 1'b1)
			run_seen[1] = 1'b1;
	end
	task automatic summarize();
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic set_ptr(input int pg, input int wd, input logic b);
		@(negedge mclk);
		ptr = (24'(pg) << (PW + 1)) | (24'(wd) << 1) | 24'(b);
	endtask : set_ptr
	task automatic load(input int pg, input int wd);
		logic [15:0] d;
		d = 16'($urandom);
		set_ptr(pg, wd, d[0]);
		dw = d;
		cpu.spm(8'h01, 1 + d[1:0]);
		if (!buf_m.exists(wd))
			buf_m[wd] = d;
		`CHK(bsel, d[0])
	endtask : load
	task automatic prog(input logic [7:0] cmd, input int pg, input bit re);
		set_ptr(pg, 0, 1'b0);
		halt_seen = 1'b0;
		run_seen = 2'b00;
		fork
			cpu.spm(cmd, 2);
			begin
				repeat (5) @(negedge mclk);
				ptr = ptr ^ 24'h00FF00;
			end
		join
		@(negedge mclk);
		`CHK(page, PG'(pg))
		// Halting section starts at page 0x3C0 with default sizes
		`CHK(halt_seen, 1'(pg >= 'h3C0))
		`CHK(run_seen, {cmd[2], !cmd[2]})
		`CHK(spc[6], 1'b1)
		`CHK(crb, 1'b1)
		`CHK(spm_irq, cmd[7])
		if (cmd[2])
			buf_m.delete();
		if (re) begin
			cpu.spm(8'h11, 3);
			buf_m.delete();
			`CHK(spc[6], 1'b0)
			`CHK(crb, 1'b0)
		end
	endtask : prog
	initial begin
		int pa, pb, i, dummy;
		dummy = $urandom(8);
		repeat (16) @(negedge mclk);
		srst = 1'b0;
		pa = 'h100 + $urandom % 'hE0;
		pb = $urandom % 'h100;
		for (i = 0; i < 6; i++)
			load(pa, (i * 37 + 5) % 128);
		load(pa, 5);
		`CHK(rvec, 24'h000000)
		prog(8'h03, pa, 0);
		prog(8'h05, pa, 0);
		prog(8'h05, pa, 1);
		prog(8'h83, 'h3C0 + $urandom % 64, 1);
		prog(8'h03, pb, 1);
		load(pb, 127);
		prog(8'h05, pb, 1);
		load(pb, 9);
		cpu.spm(8'h11, 1);
		buf_m.delete();
		load(pb, 3);
		eeprom_busy = 1'b1;
		cpu.spm(8'h03, 2);
		`CHK(spc[6], 1'b0)
		eeprom_busy = 1'b0;
		buf_m.delete();
		prog(8'h05, pb, 1);
		cpu.spm(8'h03, 6);
		`CHK(spc[6], 1'b0)
		for (i = 0; i < 2; i++) begin
			@(negedge mclk);
			ptr = 24'h000001;
			dw = 16'($urandom) | 16'h00C0;
			cpu.spm(8'h89, 4);
			lock_m &= dw[5:0];
			`CHK(lock, lock_m)
		end
		srst = 1'b1;
		fuse = 1'b0;
		repeat (16) @(negedge mclk);
		srst = 1'b0;
		repeat (3) @(negedge mclk);
		`CHK(rvec, 24'h01F000)
		summarize();
	end
endmodule : flash_self_program_ctrl_tb
